// File: pce_pkg.sv
// Shared constants, types and register map of the pixel colour enhance output block
package pce_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] PCE_REG_CTRL   = 8'h00;
    localparam logic [7:0] PCE_REG_TIMING = 8'h01;
    localparam logic [7:0] PCE_REG_PAGE   = 8'h02;
    localparam logic [7:0] PCE_REG_TADDR  = 8'h03;
    localparam logic [7:0] PCE_REG_TDATA  = 8'h04;
    localparam logic [7:0] PCE_REG_STATUS = 8'h05;
    // Control register fields
    localparam int CTRL_WB_EN       = 0;
    localparam int CTRL_RELOAD      = 1;
    localparam int CTRL_PRE_DITHER  = 2;
    localparam int CTRL_POST_DITHER = 3;
    localparam int CTRL_ORDER       = 4;
    localparam int CTRL_ORDER_REG   = 5;
    localparam int CTRL_DEPTH18     = 6;
    localparam int CTRL_DUAL        = 7;
    // Timing register fields
    localparam int TIM_DE_ONLY = 0;
    localparam int TIM_HS_HIGH = 1;
    localparam int TIM_VS_HIGH = 2;
    localparam int TIM_DE_HIGH = 3;
    localparam int TIM_HIPREC  = 4;
    // Reset values
    localparam logic [7:0] PCE_CTRL_RESET   = 8'h00;
    localparam logic [7:0] PCE_TIMING_RESET = 8'h0e;
    // Table pages
    localparam logic [1:0] PCE_PAGE_RED   = 2'h0;
    localparam logic [1:0] PCE_PAGE_GREEN = 2'h1;
    localparam logic [1:0] PCE_PAGE_BLUE  = 2'h2;
    localparam logic [7:0] PCE_TADDR_LAST = 8'hff;
    // Serial frame shape: 7 bit periods per lane, clock 2 high, 3 low, 2 high
    localparam int         PCE_BITS  = 7;
    localparam int         PCE_LANES = 8;
    localparam logic [6:0] PCE_CLK_PATTERN = 7'h63;
    localparam logic [2:0] PCE_BITS_CNT    = 3'h7;
    // Table write lock states, Gray along open, locked, reload
    typedef enum logic [1:0] {
        PCE_TBL_OPEN   = 2'b00,
        PCE_TBL_LOCKED = 2'b01,
        PCE_TBL_RELOAD = 2'b11
    } pce_tbl_t;
    // Dither algorithm choice
    typedef enum logic [1:0] {
        PCE_ALG_DEFAULT = 2'b00,
        PCE_ALG_BLACK   = 2'b01,
        PCE_ALG_WHITE   = 2'b11,
        PCE_ALG_FULLSUB = 2'b10
    } pce_alg_t;
    // One pixel with its timing bits, active high
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic       de;
        logic       hs;
        logic       vs;
    } pce_pixel_t;
endpackage : pce_pkg

// File: pce_pix_if.sv
// Pixel bundle carried between the main block and its dither stages
`timescale 1ns/1ps
interface pce_pix_if;
    import pce_pkg::*;
    pce_pixel_t pix;
    modport src (output pix);
    modport snk (input pix);
endinterface : pce_pix_if

// File: pce_dither.sv
// Temporal and spatial dither stage, 8 bits to 6 bits per component
`timescale 1ns/1ps
module pce_dither
    import pce_pkg::*;
(
    input  wire logic       clk_sys,   // System clock
    input  wire logic       nrst,      // Synchronous reset, active low
    input  wire logic       step,      // One pulse per pixel
    input  wire logic       enable,    // Dither on
    input  wire logic       hi_prec,   // High precision mode
    input  wire logic [1:0] frame_ph,  // Temporal phase
    input  wire logic [1:0] line_ph,   // Line index in group
    input  wire logic [2:0] pix_ph,    // Pixel index in group
    pce_pix_if.snk          din,       // Pixel in
    pce_pix_if.src          dout       // Pixel out, one step later
);
    typedef struct packed {
        pce_pixel_t pix;
    } pce_dstate_t;

    pce_dstate_t q;
    pce_dstate_t next_q;
    logic [2:0]  thr;

    // Threshold moves with frame so each cell flickers over four frames
    function automatic logic [2:0] pce_thr(input logic [1:0] f, input logic [1:0] l,
                                           input logic [2:0] p);
        pce_thr = {p[0] ^ l[1] ^ f[0], l[0] ^ f[1] ^ p[2], p[1] ^ f[0] ^ l[0]};
    endfunction : pce_thr

    // Extend to 9 bits, pick an algorithm, round the top 6 bits
    function automatic logic [7:0] pce_dith(input logic [7:0] c, input logic hp,
                                            input logic [2:0] t);
        logic [8:0] c9;
        pce_alg_t   alg;
        c9  = hp ? {c, c[7]} : {c, 1'b0};  // R21
        alg = (c == 8'h00) ? PCE_ALG_BLACK :
              (c == 8'hff) ? PCE_ALG_WHITE :
              (c9[8:3] == 6'h3f) ? PCE_ALG_FULLSUB : PCE_ALG_DEFAULT; // R17
        case (alg)
            PCE_ALG_BLACK:   pce_dith = 8'h00;
            PCE_ALG_WHITE:   pce_dith = 8'hfc;
            PCE_ALG_FULLSUB: pce_dith = 8'hfc;
            default:         pce_dith = {c9[8:3] + {5'h00, (c9[2:0] > t)}, 2'b00}; // R19
        endcase
    endfunction : pce_dith

    assign thr = pce_thr(frame_ph, line_ph, pix_ph);

    // Low two bits forced inactive while dithering
    always_comb begin
        next_q = q;
        if (step) begin
            next_q.pix = din.pix;
            if (enable) begin
                next_q.pix.r = pce_dith(din.pix.r, hi_prec, thr);  // R16
                next_q.pix.g = pce_dith(din.pix.g, hi_prec, thr);  // R16
                next_q.pix.b = pce_dith(din.pix.b, hi_prec, thr);  // R16
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout.pix = q.pix;
endmodule : pce_dither

// File: pce_output.sv
// Pixel back end: white balance tables, two dither stages, serial frame output
// Operation
// R1: 24 or 18-bit colour, two orders each; 18-bit here ignores the order and uses the low order only.
// R2: One frame per pixel clock.
// R3: Frame clock: high 2, low 3, high 2.
// R4: Order from strap or control bit.
// R5: Order high: MSBs on fourth lanes.
// R6: Three 256 x 8-bit tables.
// R7: Enabled balance swaps in table entry.
// R8: Tables reached through registers.
// R9: Control bit enables white balance.
// R10: Host loads red, green, blue in turn.
// R11: Tables lock at enable without reload.
// R12: Reload rewrites leave pixels intact.
// R13: Reload: partial writes, no reads.
// R14: Host fills all tables, low bits zero.
// R15: Host uses post dither for 6-bit input.
// R16: Dither gives 6 bits, low bits zero.
// R17: Temporal plus spatial, special inputs.
// R18: Pre and post dither, own enables.
// R19: High precision reaches full colours.
// R20: Host sets timing mode and polarity.
// R21: Dither widens to 9 bits, four methods.
// R22: Dual: odd pixel lanes 0-3, even 4-7.
// R23: Phase per frame, position per pixel.
`timescale 1ns/1ps
module pce_output
    import pce_pkg::*;
#(
    parameter int VBLANK_MIN = 64  // Blank pixels ending a DE-only frame
)(
    input  wire logic            clk_sys,                // System clock, 125 MHz
    input  wire logic            nrst,                   // Synchronous reset, active low
    input  wire logic [7:0]      reg_addr,               // Register address
    input  wire logic [7:0]      reg_wdata,              // Register write data
    input  wire logic            reg_wr,                 // Write strobe
    input  wire logic            reg_rd,                 // Read strobe
    output logic      [7:0]      reg_rdata,              // Read data, cycle after strobe
    input  wire logic            config_strap_pin_zero,  // Strap for bit order
    input  wire logic            pclk_in,                // Recovered pixel clock
    input  wire logic [7:0]      pix_r,                  // Red in
    input  wire logic [7:0]      pix_g,                  // Green in
    input  wire logic [7:0]      pix_b,                  // Blue in
    input  wire logic            pix_de,                 // Data enable in
    input  wire logic            pix_hs,                 // Line sync in
    input  wire logic            pix_vs,                 // Frame sync in
    output logic [PCE_LANES-1:0] lane_data,              // Serial data lanes
    output logic                 lvds_clock_out_a,       // Link A clock
    output logic                 lvds_clock_out_b,       // Link B clock
    output logic                 frame_start             // Pulse one cycle before the first bit of a frame
);
    initial begin
        if (VBLANK_MIN < 1 || VBLANK_MIN > 65535) begin
            $error("VBLANK_MIN out of range");
        end
    end

    localparam logic [15:0] VBLANK_CNT = 16'(VBLANK_MIN);

    localparam int SHIFT_W = PCE_LANES * PCE_BITS;

    typedef struct packed {
        logic                 pclk_s1;
        logic                 pclk_s2;
        logic                 pclk_d;
        pce_pixel_t           pin_s1;
        pce_pixel_t           pin_s2;
        logic                 strap_s1;
        logic                 strap_s2;
        logic [7:0]           ctrl;
        logic [7:0]           timing;
        logic [1:0]           page;
        logic [7:0]           taddr;
        logic [7:0]           rdata;
        pce_tbl_t             tstate;
        logic [2:0]           loaded;
        pce_pixel_t           s0;
        pce_pixel_t           lutp;
        logic [1:0]           frame_ph;
        logic [1:0]           line_ph;
        logic [2:0]           pix_ph;
        logic [15:0]          blank_cnt;
        logic                 out_de;
        logic                 pair_odd;
        logic [27:0]          hold;
        logic [SHIFT_W-1:0]   shift;
        logic [PCE_BITS-1:0]  clk_sh;
        logic [2:0]           bitcnt;
        logic                 div;
        logic [PCE_LANES-1:0] lanes;
        logic                 clk_a;
        logic                 clk_b;
        logic                 fstart;
    } pce_state_t;

    pce_state_t q;
    pce_state_t next_q;

    // Colour tables, no reset: host loads them after power-up
    logic [7:0] tbl_r [256];  // R6
    logic [7:0] tbl_g [256];  // R6
    logic [7:0] tbl_b [256];  // R6
    logic       tbl_we;
    logic       strobe;
    logic       bit_step;
    logic       order_hi;
    logic       emit;
    logic [27:0] word;
    pce_pixel_t  raw;

    pce_pix_if pre_in ();
    pce_pix_if pre_out ();
    pce_pix_if post_in ();
    pce_pix_if post_out ();

    // Four lanes of seven bits, lane 0 in the low bits
    function automatic logic [27:0] pce_map(input pce_pixel_t p, input logic hi,
                                            input logic d18);
        logic [6:0] l0;
        logic [6:0] l1;
        logic [6:0] l2;
        logic [6:0] l3;
        l0 = {p.r[7:2], p.g[2]};
        l1 = {p.g[7:3], p.b[3:2]};
        l2 = {p.b[7:4], p.hs, p.vs, p.de};
        l3 = {p.r[1:0], p.g[1:0], p.b[1:0], 1'b0};
        if (d18) begin
            l3 = 7'h00;  // R1
        end else if (hi) begin
            l0 = {p.r[5:0], p.g[0]};  // R5
            l1 = {p.g[5:1], p.b[1:0]};
            l2 = {p.b[5:2], p.hs, p.vs, p.de};
            l3 = {p.r[7:6], p.g[7:6], p.b[7:6], 1'b0};  // R5
        end
        pce_map = {l3, l2, l1, l0};
    endfunction : pce_map

    assign strobe   = q.pclk_s2 & ~q.pclk_d;
    assign bit_step = ~q.ctrl[CTRL_DUAL] | q.div;
    assign order_hi = q.ctrl[CTRL_ORDER_REG] ? q.ctrl[CTRL_ORDER] : q.strap_s2;  // R4
    assign word     = pce_map(post_out.pix, order_hi, q.ctrl[CTRL_DEPTH18]);     // R1
    assign pre_in.pix  = q.s0;
    assign post_in.pix = q.lutp;

    // Polarity fold so everything downstream sees active high timing
    always_comb begin
        raw    = q.pin_s2;
        raw.de = q.pin_s2.de ~^ q.timing[TIM_DE_HIGH];  // R20
        raw.hs = q.pin_s2.hs ~^ q.timing[TIM_HS_HIGH];
        raw.vs = q.pin_s2.vs ~^ q.timing[TIM_VS_HIGH];
    end

    // Single link sends every pixel; dual sends on the second of each pair
    assign emit = strobe & (~q.ctrl[CTRL_DUAL] | q.pair_odd);  // R2

    always_comb begin
        next_q = q;
        tbl_we = 1'b0;
        // Two-flop synchronisers for pins from the link side
        next_q.pclk_s1  = pclk_in;
        next_q.pclk_s2  = q.pclk_s1;
        next_q.pclk_d   = q.pclk_s2;
        next_q.pin_s1   = {pix_r, pix_g, pix_b, pix_de, pix_hs, pix_vs};
        next_q.pin_s2   = q.pin_s1;
        next_q.strap_s1 = config_strap_pin_zero;
        next_q.strap_s2 = q.strap_s1;
        next_q.fstart   = 1'b0;
        next_q.rdata    = 8'h00;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == PCE_REG_CTRL) begin
                next_q.ctrl = reg_wdata;  // R9
            end else if (reg_addr == PCE_REG_TIMING) begin
                next_q.timing = reg_wdata;
            end else if (reg_addr == PCE_REG_PAGE) begin
                next_q.page = reg_wdata[1:0];
            end else if (reg_addr == PCE_REG_TADDR) begin
                next_q.taddr = reg_wdata;
            end else if (reg_addr == PCE_REG_TDATA) begin
                // Locked tables silently drop writes, address does not move
                if (q.tstate != PCE_TBL_LOCKED && q.page <= PCE_PAGE_BLUE) begin  // R11
                    tbl_we       = 1'b1;  // R8
                    next_q.taddr = q.taddr + 8'h01;
                    if (q.taddr == PCE_TADDR_LAST) begin
                        next_q.loaded[q.page] = 1'b1;
                    end
                end
            end
        end

        // Register reads, data valid only in the following cycle
        if (reg_rd) begin
            if (reg_addr == PCE_REG_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (reg_addr == PCE_REG_TIMING) begin
                next_q.rdata = q.timing;
            end else if (reg_addr == PCE_REG_PAGE) begin
                next_q.rdata = {6'h00, q.page};
            end else if (reg_addr == PCE_REG_TADDR) begin
                next_q.rdata = q.taddr;
            end else if (reg_addr == PCE_REG_TDATA) begin
                // Reload mode reads zero; tables may be mid-update
                if (q.tstate != PCE_TBL_RELOAD) begin  // R13
                    if (q.page == PCE_PAGE_RED) begin
                        next_q.rdata = tbl_r[q.taddr];  // R8
                    end else if (q.page == PCE_PAGE_GREEN) begin
                        next_q.rdata = tbl_g[q.taddr];
                    end else if (q.page == PCE_PAGE_BLUE) begin
                        next_q.rdata = tbl_b[q.taddr];
                    end
                end
            end else if (reg_addr == PCE_REG_STATUS) begin
                next_q.rdata = {q.strap_s2, q.tstate, q.loaded, q.frame_ph};
            end
        end

        // Table lock sequence
        case (q.tstate)
            PCE_TBL_OPEN: begin
                if (q.ctrl[CTRL_WB_EN]) begin
                    next_q.tstate = q.ctrl[CTRL_RELOAD] ? PCE_TBL_RELOAD : PCE_TBL_LOCKED; // R11
                end
            end
            PCE_TBL_LOCKED: begin
                if (q.ctrl[CTRL_RELOAD]) begin
                    next_q.tstate = PCE_TBL_RELOAD;  // R12
                end
            end
            PCE_TBL_RELOAD: begin
                if (!q.ctrl[CTRL_RELOAD]) begin
                    next_q.tstate = PCE_TBL_LOCKED;
                end
            end
            default: begin
                next_q.tstate = PCE_TBL_OPEN;
            end
        endcase

        // Per-pixel pipeline: capture, pre dither, table, post dither, map
        if (strobe) begin
            next_q.s0 = raw;
            next_q.lutp = pre_out.pix;
            if (q.ctrl[CTRL_WB_EN]) begin
                next_q.lutp.r = tbl_r[pre_out.pix.r];  // R7
                next_q.lutp.g = tbl_g[pre_out.pix.g];  // R7
                next_q.lutp.b = tbl_b[pre_out.pix.b];  // R7
            end

            // Screen position for the dither pattern
            if (raw.de && !q.s0.de) begin
                next_q.pix_ph = 3'h0;
                if (q.timing[TIM_DE_ONLY] && q.blank_cnt >= VBLANK_CNT) begin
                    next_q.frame_ph = q.frame_ph + 2'h1;  // R23
                    next_q.line_ph  = 2'h0;
                end
            end else if (raw.de) begin
                next_q.pix_ph = q.pix_ph + 3'h1;
            end
            if (!raw.de && q.s0.de) begin
                next_q.line_ph = q.line_ph + 2'h1;  // R23
            end
            if (!q.timing[TIM_DE_ONLY] && raw.vs && !q.s0.vs) begin
                next_q.frame_ph = q.frame_ph + 2'h1;  // R23
                next_q.line_ph  = 2'h0;
            end
            next_q.blank_cnt = raw.de ? 16'h0000 :
                               (q.blank_cnt == 16'hffff ? q.blank_cnt : q.blank_cnt + 16'h0001);

            // Pairing restarts at every rise of data enable
            next_q.out_de = post_out.pix.de;
            if (post_out.pix.de && !q.out_de) begin
                next_q.pair_odd = 1'b1;  // R22
            end else begin
                next_q.pair_odd = ~q.pair_odd;
            end
            if (!q.pair_odd || (post_out.pix.de && !q.out_de)) begin
                next_q.hold = word;  // R22
            end
        end

        // Bit divider: dual link runs bits at half rate
        next_q.div = q.ctrl[CTRL_DUAL] ? ~q.div : 1'b1;

        // Serialiser: load a whole frame, then shift one bit per bit period
        if (emit && !(q.ctrl[CTRL_DUAL] && post_out.pix.de && !q.out_de)) begin
            if (q.ctrl[CTRL_DUAL]) begin
                next_q.shift = {word, q.hold};  // R22
            end else begin
                next_q.shift = {28'h0000000, word};
            end
            next_q.clk_sh = PCE_CLK_PATTERN;  // R3
            next_q.bitcnt = PCE_BITS_CNT;
            next_q.fstart = 1'b1;
            next_q.div    = 1'b0;
        end else if (bit_step && q.bitcnt != 3'h0) begin
            for (int i = 0; i < PCE_LANES; i++) begin
                next_q.shift[i*PCE_BITS +: PCE_BITS] =
                    {q.shift[i*PCE_BITS +: PCE_BITS-1], 1'b0};
            end
            next_q.clk_sh = {q.clk_sh[PCE_BITS-2:0], 1'b1};  // R3
            next_q.bitcnt = q.bitcnt - 3'h1;
        end
        for (int i = 0; i < PCE_LANES; i++) begin
            next_q.lanes[i] = (q.bitcnt != 3'h0) & q.shift[i*PCE_BITS + PCE_BITS - 1];
        end
        // Clock idles high between frames, the pattern ends high anyway
        next_q.clk_a = q.clk_sh[PCE_BITS-1];
        next_q.clk_b = q.clk_sh[PCE_BITS-1] & q.ctrl[CTRL_DUAL];
    end

    // Table writes through the data register
    always_ff @(posedge clk_sys) begin
        if (tbl_we) begin
            if (q.page == PCE_PAGE_RED) begin
                tbl_r[q.taddr] <= reg_wdata;
            end else if (q.page == PCE_PAGE_GREEN) begin
                tbl_g[q.taddr] <= reg_wdata;
            end else begin
                tbl_b[q.taddr] <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q        <= '0;
            q.ctrl   <= PCE_CTRL_RESET;
            q.timing <= PCE_TIMING_RESET;
            q.tstate <= PCE_TBL_OPEN;
        end else begin
            q <= next_q;
        end
    end

    // Dither stage ahead of the tables
    pce_dither u_pre (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .step     (strobe),
        .enable   (q.ctrl[CTRL_PRE_DITHER]),   // R18
        .hi_prec  (q.timing[TIM_HIPREC]),
        .frame_ph (q.frame_ph),
        .line_ph  (q.line_ph),
        .pix_ph   (q.pix_ph),
        .din      (pre_in.snk),
        .dout     (pre_out.src)
    );

    // Dither stage after the tables
    pce_dither u_post (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .step     (strobe),
        .enable   (q.ctrl[CTRL_POST_DITHER]),  // R18
        .hi_prec  (q.timing[TIM_HIPREC]),
        .frame_ph (q.frame_ph),
        .line_ph  (q.line_ph),
        .pix_ph   (q.pix_ph),
        .din      (post_in.snk),
        .dout     (post_out.src)
    );

    assign reg_rdata        = q.rdata;
    assign lane_data        = q.lanes;
    assign lvds_clock_out_a = q.clk_a;
    assign lvds_clock_out_b = q.clk_b;
    assign frame_start      = q.fstart;
endmodule : pce_output

// File: pce_output_properties.sv
// Port assertions of the pixel colour enhance output block
`timescale 1ns/1ps
module pce_output_properties
    import pce_pkg::*;
(
    input wire logic       clk_sys,          // Clock
    input wire logic       nrst,             // Reset, active low
    input wire logic [7:0] reg_addr,         // Address
    input wire logic [7:0] reg_wdata,        // Write data
    input wire logic       reg_wr,           // Write strobe
    input wire logic       reg_rd,           // Read strobe
    input wire logic [7:0] reg_rdata,        // Read data
    input wire logic [7:0] lane_data,        // Lanes
    input wire logic       lvds_clock_out_a, // Link A clock
    input wire logic       lvds_clock_out_b, // Link B clock
    input wire logic       frame_start       // Frame load
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Single link clock shape per frame
    sequence clk_shape;
        lvds_clock_out_a [*2] ##1 !lvds_clock_out_a [*3] ##1 lvds_clock_out_a [*2];
    endsequence
    // Write, then read of same register
    sequence write_then_read;
        reg_wr && reg_addr <= PCE_REG_TIMING ##1 reg_rd && reg_addr == $past(reg_addr);
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_a: assert property (reg_rd && reg_addr > PCE_REG_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    reg_back_a: assert property (write_then_read |=> reg_rdata == $past(reg_wdata, 2))
        else $error("register read back differs");
    frame_clock_a: assert property (frame_start |=> clk_shape)
        else $error("link clock shape wrong");
    clock_fall_a: assert property ($fell(lvds_clock_out_a) |-> $past(frame_start, 3))
        else $error("link clock fell off its slot");
    start_gap_a: assert property (frame_start |=> !frame_start [*6])
        else $error("frame cut short");
    lane_idle_a: assert property (frame_start ##7 !frame_start |=> lane_data == 8'h00)
        else $error("lanes not idle after frame");
    clk_b_a: assert property (lvds_clock_out_b |-> lvds_clock_out_a)
        else $error("link B clock apart from A");
endmodule : pce_output_properties
bind pce_output pce_output_properties pce_output_properties_i (.*);

// File: pce_panel_model.sv
// Panel receiver model: gathers one serial frame of link A after each start
`timescale 1ns/1ps
module pce_panel_model (
    input  wire logic            clk_sys,     // System clock
    input  wire logic [7:0]      lane_data,   // Serial lanes
    input  wire logic            frame_start, // Frame load pulse
    output logic      [3:0][6:0] word,        // Lanes 0-3, first bit on top
    output logic                 got = 1'b0   // Whole frame taken
);
    int cnt = 0;
    // Seven bits, a cycle after the start
    always @(posedge clk_sys) begin
        got <= cnt == 1;
        cnt <= frame_start ? 7 : (cnt > 0 ? cnt - 1 : 0);
        if (cnt > 0) begin
            for (int l = 0; l < 4; l++) word[l] <= {word[l][5:0], lane_data[l]};
        end
    end
endmodule : pce_panel_model

// File: test_pce_output.sv
// Self-checking bench of the pixel colour enhance output block
`timescale 1ns/1ps
module test_pce_output;
    import pce_pkg::*;
    logic            clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic            strap = 1'b0, pclk = 1'b0, clk_a, clk_b, fs, got;
    logic [7:0]      reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lanes;
    logic [7:0]      pr = 8'h9c, pg = 8'h35, pb = 8'he1;
    logic [3:0][6:0] word;
    int              n_errors = 0, samples_checked = 0, ph = 0;
    always #4 clk_sys = ~clk_sys;
    // 64 ns pixel clock
    always @(posedge clk_sys) begin
        ph <= ph + 1;
        if (ph % 4 == 3) pclk <= ~pclk;
    end
    pce_output #(.VBLANK_MIN(4)) pce_output_i (.clk_sys(clk_sys), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .config_strap_pin_zero(strap), .pclk_in(pclk), .pix_r(pr),
        .pix_g(pg), .pix_b(pb), .pix_de(1'b1), .pix_hs(1'b0), .pix_vs(1'b0), .lane_data(lanes),
        .lvds_clock_out_a(clk_a), .lvds_clock_out_b(clk_b), .frame_start(fs));
    pce_panel_model pce_panel_model_i (.clk_sys(clk_sys), .lane_data(lanes),
        .frame_start(fs), .word(word), .got(got));
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Back-to-back writes; frm or rdc drops the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check({20'h00000, reg_rdata}, {20'h00000, e}, what);
    endtask : rdc
    // Drop write strobe, flush ten frames, judge the last
    task automatic frm(input logic [27:0] m, input logic [27:0] e, input string what);
        int w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        repeat (10) begin
            for (w = 0; w < 40 && got !== 1'b1; w++) @(posedge clk_sys);
            if (w == 40) begin
                n_errors++;
                summarize;
            end
            @(posedge clk_sys);
        end
        check(word & m, e & m, what);
    endtask : frm
    function automatic logic [7:0] ent(input logic [1:0] p, input logic [7:0] a);
        return ~a - {6'h00, p};
    endfunction : ent
    // Expected lanes, de high
    function automatic logic [27:0] map(input logic [7:0] r, g, b, input logic msb);
        if (msb) return {r[7:6], g[7:6], b[7:6], 1'b0, b[5:2], 3'h1, g[5:1], b[1:0], r[5:0], g[0]};
        return {r[1:0], g[1:0], b[1:0], 1'b0, b[7:4], 3'h1, g[7:3], b[3:2], r[7:2], g[2]};
    endfunction : map
    task automatic t_load;
        rdc(PCE_REG_CTRL, PCE_CTRL_RESET, "ctrl reset");
        rdc(PCE_REG_TIMING, PCE_TIMING_RESET, "timing reset");
        rdc(8'h3c, 8'h00, "unmapped read");
        for (int p = 0; p < 3; p++) begin
            wr(PCE_REG_PAGE, 8'(p));
            wr(PCE_REG_TADDR, 8'h00);
            for (int a = 0; a < 256; a++) wr(PCE_REG_TDATA, ent(2'(p), 8'(a)));
        end
        wr(PCE_REG_TADDR, 8'h10);
        rdc(PCE_REG_TDATA, ent(2'h2, 8'h10), "blue entry");
        frm('1, map(pr, pg, pb, 1'b0), "plain frame");
        $display("load done");
    endtask : t_load
    task automatic t_wb_lock;
        wr(PCE_REG_CTRL, 8'h01);
        rdc(PCE_REG_CTRL, 8'h01, "ctrl wb");
        frm('1, map(ent(2'h0, pr), ent(2'h1, pg), ent(2'h2, pb), 1'b0), "balanced");
        wr(PCE_REG_PAGE, 8'h00);
        wr(PCE_REG_TADDR, pr);
        wr(PCE_REG_TDATA, 8'h00);
        rdc(PCE_REG_TADDR, pr, "locked addr");
        frm('1, map(ent(2'h0, pr), ent(2'h1, pg), ent(2'h2, pb), 1'b0), "locked");
        wr(PCE_REG_CTRL, 8'h03);
        rdc(PCE_REG_CTRL, 8'h03, "ctrl reload");
        wr(PCE_REG_TADDR, pr);
        wr(PCE_REG_TDATA, 8'h40);
        rdc(PCE_REG_TDATA, 8'h00, "reload read");
        frm('1, map(8'h40, ent(2'h1, pg), ent(2'h2, pb), 1'b0), "reloaded");
        $display("white balance done");
    endtask : t_wb_lock
    task automatic t_order_dither;
        wr(PCE_REG_CTRL, 8'h31);
        rdc(PCE_REG_CTRL, 8'h31, "ctrl order");
        frm('1, map(8'h40, ent(2'h1, pg), ent(2'h2, pb), 1'b1), "msb order");
        wr(PCE_REG_CTRL, 8'h01);
        strap <= 1'b1;
        frm('1, map(8'h40, ent(2'h1, pg), ent(2'h2, pb), 1'b1), "strap order");
        strap <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(PCE_REG_CTRL, i == 0 ? 8'h04 : (i == 1 ? 8'h09 : 8'h41));
            frm({7'h7f, 21'h000000}, 28'h0000000, "low lane idle");
        end
        $display("order and dither done");
    endtask : t_order_dither
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        t_load;
        t_wb_lock;
        t_order_dither;
        summarize;
    end
endmodule : test_pce_output
